// *** common/protocol_sequence_executor_consts.svh ***
// Offsets, error codes and timing counts of the protocol sequence executor.
// Assumes a 100 MHz module clock; included by bare name.
`ifndef PROTOCOL_SEQUENCE_EXECUTOR_CONSTS_SVH
`define PROTOCOL_SEQUENCE_EXECUTOR_CONSTS_SVH

`define PSE_MAX_PROTOCOLS 4'h8
`define PSE_CTRL_WORDS 18
`define PSE_WORD_COUNT 5'h00
`define PSE_WORD_STATUS 5'h01
`define PSE_WORD_PACKET0 5'h0A
`define PSE_ERR_NONE 16'h0000
`define PSE_ERR_CANCEL 16'hC404
`define PSE_ERR_CONN_SETTING 16'hC407
`define PSE_ERR_SETTING_WRITE 16'hC430
`define PSE_ERR_PAIR_BUSY 16'hC4F0
`define PSE_ERR_NOT_PROTOCOL 16'hC4F1
`define PSE_CLK_MHZ 100
`define PSE_POLL_NS 1000
`define PSE_POLL_CYCLES ((`PSE_POLL_NS * `PSE_CLK_MHZ) / 1000)

`endif

// *** common/protocol_sequence_executor_pkg.sv ***
// Types shared by the protocol sequence executor and its helpers.
// Assumes the constants header for numeric values.
package protocol_sequence_executor_pkg;

  typedef enum logic [1:0] {
    CANCEL_NONE = 2'b00,
    CANCEL_REQUESTED = 2'b01,
    CANCEL_DONE = 2'b10
  } conn_cancel_t;

  typedef enum logic [1:0] {
    COMM_SEND_ONLY = 2'b00,
    COMM_RECV_ONLY = 2'b01,
    COMM_SEND_RECV = 2'b10
  } comm_type_t;

  typedef enum logic [1:0] {
    FIXED_NONE = 2'b00,
    FIXED_SEND = 2'b01,
    FIXED_RECV = 2'b10
  } fixed_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CLEAR = 3'b001,
    ST_START = 3'b010,
    ST_RUN = 3'b011,
    ST_ABORT = 3'b100,
    ST_WCOUNT = 3'b101,
    ST_WSTAT = 3'b110
  } exec_state_t;

  typedef struct packed {
    logic [3:0] connectionSelectOperand;
    logic [3:0] protocolCountOperand;
    logic [7:0][7:0] protocolNumbers;
  } invoke_req_t;

  typedef struct packed {
    logic start;
    logic abort;
    logic [3:0] conn;
    logic [7:0] protoNumber;
  } eng_cmd_t;

  typedef struct packed {
    logic done;
    logic error;
    logic [15:0] errCode;
    logic [4:0] matchedPacket;
  } eng_result_t;

endpackage : protocol_sequence_executor_pkg

// *** core/cancel_state_tracker.sv ***
// Cancellation state of one connection.
// Assumes request, running and finish come from logic on sys_clk.
`timescale 1ns/1ns
`default_nettype none
module cancel_state_tracker
  import protocol_sequence_executor_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic cancelReq,
  input wire logic running,
  input wire logic finish,
  output conn_cancel_t state
);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= CANCEL_NONE;
    end else if (cancelReq && running) begin
      state <= CANCEL_REQUESTED;
    end else if (finish && state == CANCEL_REQUESTED) begin
      state <= CANCEL_DONE;
    end
  end

  property p_idle_request_ignored;
    @(posedge sys_clk) disable iff (!reset_n)
      (cancelReq && !running && state == CANCEL_NONE) |=> state == CANCEL_NONE;
  endproperty
  a_idle_request_ignored: assert property (p_idle_request_ignored)
    else $error("cancel request without running protocol changed state");

  property p_never_back_to_none;
    @(posedge sys_clk) disable iff (!reset_n)
      state != CANCEL_NONE |=> state != CANCEL_NONE;
  endproperty
  a_never_back_to_none: assert property (p_never_back_to_none)
    else $error("cancel state returned to never-requested");

endmodule : cancel_state_tracker
`default_nettype wire

// *** core/result_word_memory.sv ***
// Word store for the control data block, registered read port.
// Assumes one writer and one reader on sys_clk.
`timescale 1ns/1ns
`default_nettype none
module result_word_memory #(
  parameter int WORDS = 18,
  parameter int WIDTH = 16,
  parameter int AW = 5
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic [AW-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData
);

  logic [WIDTH-1:0] mem [WORDS];

  always_ff @(posedge sys_clk) begin
    if (wrEn && int'(wrAddr) < WORDS) begin
      mem[wrAddr] <= wrData;
    end
  end

  // Unmapped words read as zero
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdData <= '0;
    end else if (int'(rdAddr) < WORDS) begin
      rdData <= mem[rdAddr];
    end else begin
      rdData <= '0;
    end
  end

endmodule : result_word_memory
`default_nettype wire

// *** core/protocol_sequence_executor.sv ***
// Sequencer that runs registered protocols back to back on one connection.
// Assumes the protocol engine, scan-end strobe and CPU inputs share sys_clk.
`timescale 1ns/1ns
`default_nettype none
`include "protocol_sequence_executor_consts.svh"

// Overview of operation
// - One invocation runs the requested protocols in order, eight at most.
// - Executed protocol count goes into control data word zero.
// - Completion flag rises at scan end after finishing, falls next scan end.
// - Error flag stays low on success, pulses with completion on error.
// - Cancel stops current protocol, ends with error, skips the rest.
// - A frame already being sent is finished; otherwise nothing moves.
// - Cancel state starts never-requested, goes requested, then completed, never back.
// - Cancel request with no protocol running does nothing.
// - Cancel requests are polled periodically, so termination may lag.
// - No new invocation starts while the connection's cancel is requested.
// - A failing protocol stops the sequence; invocation ends with error.
// - Invocations accepted only on connections set for communication protocol.
// - Cancel in protocol m stores count m, earlier packets, code C404H.
// - Setting data rewritten mid-run cancels after the write, code C430H.
// - Fixed-buffer direction clashing with communication type ends with C407H.
// - Infinite receive wait means no completion until data arrives.
// - Later invocation on a busy connection is ignored, not executed.
// - Later invocation on a busy paired connection completes with error.
// - Matched receive packet stored per protocol; zero otherwise.
module protocol_sequence_executor
  import protocol_sequence_executor_pkg::*;
#(
  parameter int NUM_CONN = 16
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic protocolExecuteInstruction,
  input wire invoke_req_t invoke,
  input wire logic [NUM_CONN-1:0] connIsProtocol,
  input wire logic [NUM_CONN-1:0] connPaired,
  input wire logic [2*NUM_CONN-1:0] connFixedMode,
  input wire logic [NUM_CONN-1:0] cancelRequest,
  input wire logic settingWriteBusy,
  input wire logic scanEnd,
  input wire comm_type_t protoCommType,
  input wire eng_result_t engResult,
  input wire logic [4:0] ctrlReadAddr,
  output eng_cmd_t engCmd,
  output logic [2*NUM_CONN-1:0] cancelState,
  output logic completeFlag,
  output logic errorFlag,
  output logic rejectFlag,
  output logic [15:0] rejectCode,
  output logic [15:0] ctrlReadData
);

  exec_state_t state;
  logic [3:0] curConn;
  logic [3:0] curCount;
  logic [3:0] protoIdx;
  logic [2:0] clrIdx;
  logic [7:0][7:0] curList;
  logic [15:0] errCode;
  logic [3:0] execCount;
  logic memWe;
  logic [4:0] memAddr;
  logic [15:0] memData;
  logic cancelSeen;
  logic writeSeen;
  logic finishPulse;
  logic finishPending;
  logic finishErr;
  logic rejectPending;
  logic [15:0] rejectPendingCode;
  logic [$clog2(`PSE_POLL_CYCLES)-1:0] pollCount;
  logic pollTick;
  logic [3:0] invConn;
  logic connOk;
  logic invCancelReq;
  logic accept;
  logic rejectNotProto;
  logic rejectPair;
  logic running;
  logic curCancelReq;
  logic dirClash;
  logic writeFinished;
  fixed_mode_t curFixed;
  assign running = (state != ST_IDLE);
  assign invConn = invoke.connectionSelectOperand;
  assign connOk = int'(invConn) < NUM_CONN;
  assign invCancelReq = connOk && (cancelState[2*invConn +: 2] == CANCEL_REQUESTED);
  assign curCancelReq = cancelState[2*curConn +: 2] == CANCEL_REQUESTED;
  assign rejectNotProto = protocolExecuteInstruction && connOk && !connIsProtocol[invConn];
  // Same connection busy: paired connections answer with an error, others stay silent
  assign rejectPair = protocolExecuteInstruction && running && connOk && !rejectNotProto
    && invConn == curConn && connPaired[invConn];
  assign accept = protocolExecuteInstruction && !running && connOk
    && connIsProtocol[invConn] && !invCancelReq;
  assign curFixed = fixed_mode_t'(connFixedMode[2*curConn +: 2]);
  assign dirClash = (curFixed == FIXED_SEND && protoCommType == COMM_RECV_ONLY)
    || (curFixed == FIXED_RECV && protoCommType == COMM_SEND_ONLY);
  assign writeFinished = writeSeen && !settingWriteBusy;
  assign pollTick = (pollCount == '0);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CONN; gi++) begin : g_cancel
      cancel_state_tracker u_tracker (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .cancelReq(cancelRequest[gi]),
        .running(running && int'(curConn) == gi),
        .finish(finishPulse && int'(curConn) == gi),
        .state(cancelState[2*gi +: 2])
      );
    end
  endgenerate

  result_word_memory #(
    .WORDS(`PSE_CTRL_WORDS),
    .WIDTH(16),
    .AW(5)
  ) controlDataBlock (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .wrEn(memWe),
    .wrAddr(memAddr),
    .wrData(memData),
    .rdAddr(ctrlReadAddr),
    .rdData(ctrlReadData)
  );

  // Cancel is sampled only on the poll tick, trading latency for a cheap check
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pollCount <= '0;
    end else if (pollTick) begin
      pollCount <= ($clog2(`PSE_POLL_CYCLES))'(`PSE_POLL_CYCLES - 1);
    end else begin
      pollCount <= pollCount - 1'b1;
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cancelSeen <= 1'b0;
    end else if (accept) begin
      cancelSeen <= 1'b0;
    end else if (running && pollTick && curCancelReq) begin
      cancelSeen <= 1'b1;
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      writeSeen <= 1'b0;
    end else begin
      writeSeen <= running && settingWriteBusy;
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      curConn <= 4'h0;
      curCount <= 4'h0;
      protoIdx <= 4'h0;
      clrIdx <= 3'h0;
      curList <= '0;
      errCode <= `PSE_ERR_NONE;
      execCount <= 4'h0;
      memWe <= 1'b0;
      memAddr <= 5'h00;
      memData <= 16'h0000;
      engCmd <= '0;
      finishPulse <= 1'b0;
    end else begin
      memWe <= 1'b0;
      finishPulse <= 1'b0;
      engCmd.start <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (accept) begin
            curConn <= invConn;
            curCount <= (invoke.protocolCountOperand > `PSE_MAX_PROTOCOLS)
              ? `PSE_MAX_PROTOCOLS : invoke.protocolCountOperand;
            curList <= invoke.protocolNumbers;
            protoIdx <= 4'h0;
            clrIdx <= 3'h0;
            errCode <= `PSE_ERR_NONE;
            engCmd.conn <= invConn;
            engCmd.protoNumber <= invoke.protocolNumbers[0];
            state <= ST_CLEAR;
          end
        end
        ST_CLEAR: begin
          memWe <= 1'b1;
          memAddr <= `PSE_WORD_PACKET0 + {2'b00, clrIdx};
          memData <= 16'h0000;
          clrIdx <= clrIdx + 3'h1;
          if (clrIdx == 3'h7) begin
            state <= ST_START;
          end
        end
        ST_START: begin
          if (protoIdx == curCount) begin
            execCount <= curCount;
            state <= ST_WCOUNT;
          end else if (cancelSeen) begin
            errCode <= `PSE_ERR_CANCEL;
            execCount <= protoIdx + 4'h1;
            state <= ST_WCOUNT;
          end else if (dirClash) begin
            errCode <= `PSE_ERR_CONN_SETTING;
            execCount <= protoIdx + 4'h1;
            state <= ST_WCOUNT;
          end else begin
            engCmd.start <= 1'b1;
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          // No watchdog here: an infinite receive wait simply keeps us in this state
          if (engResult.done) begin
            if (engResult.error) begin
              errCode <= engResult.errCode;
              execCount <= protoIdx + 4'h1;
              state <= ST_WCOUNT;
            end else begin
              memWe <= 1'b1;
              memAddr <= `PSE_WORD_PACKET0 + {1'b0, protoIdx};
              memData <= {11'h000, engResult.matchedPacket};
              protoIdx <= protoIdx + 4'h1;
              engCmd.protoNumber <= curList[protoIdx[2:0] + 3'h1];
              state <= ST_START;
            end
          end else if (cancelSeen) begin
            engCmd.abort <= 1'b1;
            errCode <= `PSE_ERR_CANCEL;
            state <= ST_ABORT;
          end else if (writeFinished) begin
            engCmd.abort <= 1'b1;
            errCode <= `PSE_ERR_SETTING_WRITE;
            state <= ST_ABORT;
          end
        end
        ST_ABORT: begin
          // The engine lets a frame already on the wire finish before it reports done
          if (engResult.done) begin
            engCmd.abort <= 1'b0;
            execCount <= protoIdx + 4'h1;
            state <= ST_WCOUNT;
          end
        end
        ST_WCOUNT: begin
          memWe <= 1'b1;
          memAddr <= `PSE_WORD_COUNT;
          memData <= {12'h000, execCount};
          state <= ST_WSTAT;
        end
        ST_WSTAT: begin
          memWe <= 1'b1;
          memAddr <= `PSE_WORD_STATUS;
          memData <= errCode;
          finishPulse <= 1'b1;
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // A finish in the same cycle as scan end wins and is shown at the next scan end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      finishPending <= 1'b0;
      finishErr <= 1'b0;
    end else if (finishPulse) begin
      finishPending <= 1'b1;
      finishErr <= errCode != `PSE_ERR_NONE;
    end else if (scanEnd) begin
      finishPending <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      completeFlag <= 1'b0;
      errorFlag <= 1'b0;
    end else if (scanEnd) begin
      completeFlag <= finishPending;
      errorFlag <= finishPending && finishErr;
    end else if (accept) begin
      completeFlag <= 1'b0;
      errorFlag <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rejectPending <= 1'b0;
      rejectPendingCode <= `PSE_ERR_NONE;
      rejectFlag <= 1'b0;
      rejectCode <= `PSE_ERR_NONE;
    end else begin
      if (rejectNotProto || rejectPair) begin
        rejectPending <= 1'b1;
        rejectPendingCode <= rejectNotProto ? `PSE_ERR_NOT_PROTOCOL : `PSE_ERR_PAIR_BUSY;
      end else if (scanEnd) begin
        rejectPending <= 1'b0;
      end
      if (scanEnd) begin
        rejectFlag <= rejectPending;
        rejectCode <= rejectPending ? rejectPendingCode : `PSE_ERR_NONE;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_finish;
    state == ST_WCOUNT ##1 state == ST_WSTAT ##1 state == ST_IDLE;
  endsequence
  property p_count_limit;
    running |-> curCount <= `PSE_MAX_PROTOCOLS && protoIdx <= curCount;
  endproperty
  a_count_limit: assert property (p_count_limit)
    else $error("protocol count beyond eight");
  property p_flag_changes_on_scan;
    $changed(completeFlag) && !$past(accept) |-> $past(scanEnd);
  endproperty
  a_flag_changes_on_scan: assert property (p_flag_changes_on_scan)
    else $error("completion flag moved outside scan end");
  property p_error_with_complete;
    errorFlag |-> completeFlag;
  endproperty
  a_error_with_complete: assert property (p_error_with_complete)
    else $error("error flag without completion flag");
  property p_fail_stops;
    (state == ST_RUN && engResult.done && engResult.error) |=> !engCmd.start throughout s_finish;
  endproperty
  a_fail_stops: assert property (p_fail_stops)
    else $error("sequence did not stop after failing protocol");
  property p_cancel_aborts;
    (state == ST_RUN && cancelSeen && !engResult.done) |=> engCmd.abort && errCode == 16'hC404;
  endproperty
  a_cancel_aborts: assert property (p_cancel_aborts)
    else $error("seen cancel did not abort running protocol");
  // Cancel can only be requested while busy, so the check must cover the busy case too
  property p_refuse_while_cancel;
    (protocolExecuteInstruction && invCancelReq) |=> !(state == ST_CLEAR && clrIdx == 3'h0);
  endproperty
  a_refuse_while_cancel: assert property (p_refuse_while_cancel)
    else $error("invocation started while cancel requested");
  property p_not_protocol_rejected;
    (rejectNotProto && !running) |=> state == ST_IDLE && rejectPending;
  endproperty
  a_not_protocol_rejected: assert property (p_not_protocol_rejected)
    else $error("non-protocol connection accepted");
  property p_write_cancels;
    (state == ST_RUN && writeFinished && !cancelSeen && !engResult.done)
      |=> engCmd.abort && errCode == 16'hC430;
  endproperty
  a_write_cancels: assert property (p_write_cancels)
    else $error("setting write did not cancel protocol");
  property p_accept_clears;
    (accept && !scanEnd) |=> !completeFlag && !errorFlag;
  endproperty
  a_accept_clears: assert property (p_accept_clears)
    else $error("stale flags after accepting invocation");

endmodule : protocol_sequence_executor
`default_nettype wire

// *** test/protocol_engine_model.sv ***
// Behavioural protocol engine facing the executor's engine command port.
// Assumes protocol number bits: [7] fail, [6] endless receive wait, [5:4] type, [3:0] packet-1.
`timescale 1ns/1ns
`default_nettype none
`include "protocol_sequence_executor_consts.svh"
module protocol_engine_model
  import protocol_sequence_executor_pkg::*;
#(
  parameter int LAT = 20,
  parameter logic [15:0] FAIL_CODE = 16'hC0E1
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire eng_cmd_t engCmd,
  output comm_type_t protoCommType,
  output var eng_result_t engResult
);
  logic busy;
  int cnt;
  logic [7:0] num;
  assign protoCommType = comm_type_t'(engCmd.protoNumber[5:4]);
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy <= 1'b0;
      cnt <= 0;
      num <= 8'h00;
      engResult <= '0;
    end else begin
      // Fields outside done are junk, so nothing may lean on stale values
      engResult <= '{1'b0, ~engResult.error, ~engResult.errCode, ~engResult.matchedPacket};
      if (engCmd.start) begin
        busy <= 1'b1;
        cnt <= 0;
        num <= engCmd.protoNumber;
      end else if (busy) begin
        cnt <= cnt + 1;
        if (engCmd.abort && cnt >= 3) begin
          busy <= 1'b0;
          engResult <= '{1'b1, 1'b1, `PSE_ERR_CANCEL, 5'h00};
        end else if (!num[6] && cnt == LAT) begin
          busy <= 1'b0;
          if (num[7]) engResult <= '{1'b1, 1'b1, FAIL_CODE, 5'h00};
          else if (num[5:4] == 2'b00) engResult <= '{1'b1, 1'b0, 16'h0000, 5'h00};
          else engResult <= '{1'b1, 1'b0, 16'h0000, {1'b0, num[3:0]} + 5'h01};
        end
      end
    end
  end
endmodule : protocol_engine_model
`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench for the protocol sequence executor.
// Assumes the engine model above; scan end pulses every SCAN cycles.
`timescale 1ns/1ns
`default_nettype none
module tb
  import protocol_sequence_executor_pkg::*;
;
  localparam int SCAN = 50;
  localparam logic [15:0] FAIL_CODE = 16'hC0E1;
  logic sys_clk = 1'b0, reset_n = 1'b0, protocolExecuteInstruction = 1'b0;
  logic settingWriteBusy = 1'b0, scanEnd = 1'b0;
  logic [15:0] connIsProtocol = 16'hFFEF, connPaired = 16'h0002, cancelRequest = 16'h0000;
  logic [31:0] connFixedMode = 32'h0000_0040;
  logic [4:0] ctrlReadAddr = 5'h00;
  invoke_req_t invokeReq = '0;
  comm_type_t protoCommType;
  eng_result_t engResult;
  eng_cmd_t engCmd;
  logic [31:0] cancelState;
  logic completeFlag, errorFlag, rejectFlag;
  logic [15:0] rejectCode, ctrlReadData, info;
  int error_cnt = 0, num_checks = 0;
  protocol_sequence_executor dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .protocolExecuteInstruction(protocolExecuteInstruction), .invoke(invokeReq),
    .connIsProtocol(connIsProtocol), .connPaired(connPaired), .connFixedMode(connFixedMode),
    .cancelRequest(cancelRequest), .settingWriteBusy(settingWriteBusy), .scanEnd(scanEnd),
    .protoCommType(protoCommType), .engResult(engResult), .ctrlReadAddr(ctrlReadAddr),
    .engCmd(engCmd), .cancelState(cancelState), .completeFlag(completeFlag),
    .errorFlag(errorFlag), .rejectFlag(rejectFlag), .rejectCode(rejectCode),
    .ctrlReadData(ctrlReadData));
  protocol_engine_model #(.FAIL_CODE(FAIL_CODE)) engine (.sys_clk(sys_clk),
    .reset_n(reset_n), .engCmd(engCmd), .protoCommType(protoCommType), .engResult(engResult));
  always #5 sys_clk = ~sys_clk;
  always begin
    repeat (SCAN - 1) @(posedge sys_clk);
    #1 scanEnd = 1'b1;
    @(posedge sys_clk);
    #1 scanEnd = 1'b0;
  end
  task summarize();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  function automatic logic [15:0] expPkt(input logic [7:0] n);
    return (n[5:4] == 2'b00) ? 16'h0000 : {12'h000, n[3:0]} + 16'h0001;
  endfunction : expPkt
  task issue(input logic [3:0] conn, input logic [3:0] cnt, input logic [63:0] nums);
    invokeReq = '{conn, cnt, nums};
    protocolExecuteInstruction = 1'b1;
    tick(1);
    protocolExecuteInstruction = 1'b0;
  endtask : issue
  // Waits for completion or refusal, then measures that the flag stands one scan
  task waitFlag(input bit rej);
    int n;
    n = 0;
    while ((rej ? rejectFlag : completeFlag) !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
    if (n >= 3000) begin
      error_cnt++;
      $display("BAD %0t wait for flag timed out", $time);
      summarize();
    end
    info = rej ? rejectCode : {15'h0000, errorFlag};
    n = 0;
    while ((rej ? rejectFlag : completeFlag) === 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    chk(16'(n), 16'(SCAN), "flag length");
    chk({15'h0000, errorFlag}, 16'h0000, "error flag after scan");
  endtask : waitFlag
  task runChk(input logic [15:0] cnt, input logic [15:0] st, input logic [63:0] nums,
      input int good);
    logic [7:0][7:0] p;
    p = nums;
    ctrlReadAddr = 5'h00;
    tick(1);
    chk(ctrlReadData, cnt, "count word");
    ctrlReadAddr = 5'h01;
    tick(1);
    chk(ctrlReadData, st, "status word");
    for (int i = 0; i < 8; i++) begin
      ctrlReadAddr = 5'(10 + i);
      tick(1);
      chk(ctrlReadData, (i < good) ? expPkt(p[i]) : 16'h0000, "packet word");
    end
  endtask : runChk
  task scenResetIdle();
    chk(cancelState[15:0], 16'h0000, "cancel after reset");
    chk({13'h0, completeFlag, errorFlag, rejectFlag}, 16'h0000, "flags after reset");
    cancelRequest = 16'h0004;
    tick(1);
    cancelRequest = 16'h0000;
    tick(3);
    chk({14'h0, cancelState[5:4]}, 16'h0000, "idle cancel");
  endtask : scenResetIdle
  task scenGood();
    issue(4'h0, 4'h3, 64'h13_05_21);
    waitFlag(1'b0);
    chk(info, 16'h0000, "error flag on success");
    runChk(16'h0003, 16'h0000, 64'h13_05_21, 3);
    issue(4'h2, 4'h9, {8{8'h21}});
    waitFlag(1'b0);
    runChk(16'h0008, 16'h0000, {8{8'h21}}, 8);
  endtask : scenGood
  task scenFail();
    issue(4'h0, 4'h4, 64'h13_05_A0_21);
    waitFlag(1'b0);
    chk(info, 16'h0001, "error flag on failure");
    runChk(16'h0002, FAIL_CODE, 64'h13_05_A0_21, 1);
  endtask : scenFail
  task scenCancel();
    issue(4'h0, 4'h2, 64'h53_21);
    tick(100);
    issue(4'h0, 4'h1, 64'h21);
    tick(50);
    cancelRequest = 16'h0001;
    tick(1);
    cancelRequest = 16'h0000;
    chk({14'h0, cancelState[1:0]}, {14'h0, CANCEL_REQUESTED}, "cancel requested");
    issue(4'h0, 4'h1, 64'h21);
    waitFlag(1'b0);
    chk(info, 16'h0001, "error flag on cancel");
    runChk(16'h0002, 16'hC404, 64'h53_21, 1);
    chk({14'h0, cancelState[1:0]}, {14'h0, CANCEL_DONE}, "cancel done");
  endtask : scenCancel
  task scenPairedWrite();
    issue(4'h1, 4'h1, 64'h40);
    tick(30);
    issue(4'h1, 4'h1, 64'h21);
    waitFlag(1'b1);
    chk(info, 16'hC4F0, "paired busy code");
    settingWriteBusy = 1'b1;
    tick(5);
    settingWriteBusy = 1'b0;
    waitFlag(1'b0);
    chk(info, 16'h0001, "error flag on setting write");
    runChk(16'h0001, 16'hC430, 64'h40, 0);
  endtask : scenPairedWrite
  task scenRefuse();
    issue(4'h4, 4'h1, 64'h21);
    waitFlag(1'b1);
    chk(info, 16'hC4F1, "not protocol code");
    issue(4'h3, 4'h1, 64'h10);
    waitFlag(1'b0);
    runChk(16'h0001, 16'hC407, 64'h10, 0);
  endtask : scenRefuse
  initial begin
    tick(8);
    reset_n = 1'b1;
    tick(1);
    scenResetIdle();
    scenGood();
    scenFail();
    scenCancel();
    scenPairedWrite();
    scenRefuse();
    summarize();
  end
endmodule : tb
`default_nettype wire
